// ### verilog/iec_bank.sv
// error status flags and command strobe register of the interpolator
// What this block does
// - sine offset loop limit sets bit 8
// - cosine offset loop limit sets bit 7
// - sine gain loop limit sets bit 6
// - cosine gain loop limit sets bit 5
// - output invalid from overspeed sets bit 4
// - rate or edge-interval change flags invalid
// - no output-invalid detection in counter mode
// - overspeed sets bit 3
// - sine converter overdrive sets bit 2
// - cosine converter overdrive sets bit 1
// - small vector sets bit 0
// - command at 0x0b, write-only, zeros idle
// - bit 5 latches four address pins
// - bit 4 stores config to nonvolatile memory
// - bit 3 reloads config from nonvolatile memory
// - bit 2 clears index passed status
// - bit 1 centres gain/offset loops
// - bit 0 clears count, errors, index
// - status at 0x08, bit 12 index
// - errors held only when save bit set
// - detection only when monitor bit set
//
// how it behaves, for whoever wires it in:
// every register access, flag update and strobe happens on a rising edge
// with clk_en high; while clk_en is low nothing moves, not even the pin
// synchroniser, so a frozen block keeps its last strobe level too.
// the host should therefore drop clk_en only between accesses.
// detector inputs are taken as same-clock events; a level that stays
// high simply keeps setting its flag, and a clear cannot beat it.
// that is deliberate: an error that is still present must not vanish
// from the status word just because the host asked for a clear.
// the same priority holds for the index status bit, and a synced index
// also beats a lost index seen in the same cycle.
// a flag is only recorded when both its monitor bit and its save bit
// are set; the monitor bit of the output class also picks square-wave
// mode, so counter mode suppresses output-invalid events, including the
// ones raised by a rate or edge-interval change.
// the address pins pass two flip-flops first, so a latch command takes
// the pin levels from two enabled cycles before the write; pins must be
// settled that long before the command is sent.
// the command word is write-only: a read of its address answers zero
// with the usual valid pulse, so the host never sees stale command bits.
// upper status fields live in other blocks and read as zero here.
`timescale 1ns/1ps
module iec_bank
  import iec_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port from the serial interface
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  // configuration word one from the config register block
  input  wire logic [31:0] config_word_one,
  input  wire logic        rate_setting_changed,
  // raw detector pulses from the signal path
  input  wire logic        sine_offset_limit,
  input  wire logic        cosine_offset_limit,
  input  wire logic        sine_gain_limit,
  input  wire logic        cosine_gain_limit,
  input  wire logic        output_too_fast,
  input  wire logic        direction_too_fast,
  input  wire logic        sine_converter_over,
  input  wire logic        cosine_converter_over,
  input  wire logic        vector_too_small,
  input  wire logic        index_synced,
  input  wire logic        index_lost,
  // hardware address pins
  input  wire logic        address_pin_3,
  input  wire logic        address_pin_2,
  input  wire logic        address_pin_1,
  input  wire logic        address_pin_0,
  // command effects
  output logic      [3:0]  bus_address,
  output logic             store_config_cmd,
  output logic             load_config_cmd,
  output logic             reset_correction_loops_cmd,
  output logic             clear_count_and_errors_cmd,
  output logic             square_wave_mode,
  output logic      [15:0] error_status
);
  logic [3:0]  pins_sync;
  logic [ERROR_FLAG_COUNT-1:0] flags_r;
  logic [ERROR_FLAG_COUNT-1:0] detect_raw;
  logic [ERROR_FLAG_COUNT-1:0] detect_mon;
  logic [ERROR_FLAG_COUNT-1:0] detect_save;
  logic        index_r;
  logic [3:0]  address_r;
  logic        cmd_write;
  logic        clear_errors;

  // address pins come from outside, so synchronise first
  iec_sync #(.WIDTH(4)) u_pin_sync
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({address_pin_3, address_pin_2, address_pin_1, address_pin_0}),
    .sync_out (pins_sync)
  );

  // pick the enable bit of an error class for a given flag position
  function automatic logic class_enable(input logic [31:0] cfg, input int flag,
                                        input logic save);
    int base;
    int bitpos;
    base = save ? SAVE_VECTOR_BIT : MON_VECTOR_BIT;
    unique case (flag)
      SMALL_VECTOR_BIT:                   bitpos = base;
      COS_OVERDRIVE_BIT, SIN_OVERDRIVE_BIT: bitpos = base + 1;
      OVERSPEED_BIT:                      bitpos = base + 2;
      OUTPUT_INVALID_BIT:                 bitpos = base + 3;
      COS_GAIN_BIT, SIN_GAIN_BIT:         bitpos = base + 4;
      default:                            bitpos = base + 5;
    endcase
    return cfg[bitpos];
  endfunction

  // command decode; a write anywhere else never touches commands
  assign cmd_write    = reg_wr && (reg_addr == COMMAND_ADDR);
  assign clear_errors = cmd_write && reg_wdata[CLEAR_COUNT_BIT];

  // gather raw detector events into flag order
  always_comb
  begin
    detect_raw                     = '0;
    detect_raw[SIN_OFFSET_BIT]     = sine_offset_limit;
    detect_raw[COS_OFFSET_BIT]     = cosine_offset_limit;
    detect_raw[SIN_GAIN_BIT]       = sine_gain_limit;
    detect_raw[COS_GAIN_BIT]       = cosine_gain_limit;
    detect_raw[OUTPUT_INVALID_BIT] = output_too_fast || rate_setting_changed;
    detect_raw[OVERSPEED_BIT]      = direction_too_fast;
    detect_raw[SIN_OVERDRIVE_BIT]  = sine_converter_over;
    detect_raw[COS_OVERDRIVE_BIT]  = cosine_converter_over;
    detect_raw[SMALL_VECTOR_BIT]   = vector_too_small;
  end

  // monitor bit for output errors doubles as mode select; counter mode
  // therefore disables output-invalid detection by the same gate
  assign square_wave_mode = config_word_one[MON_OUTPUT_BIT];

  // per-flag gating by monitor and save enables
  genvar g;
  generate
    for (g = 0; g < ERROR_FLAG_COUNT; g++)
    begin : g_flag
      assign detect_mon[g]  = detect_raw[g] && class_enable(config_word_one, g, 1'b0);
      assign detect_save[g] = detect_mon[g] && class_enable(config_word_one, g, 1'b1);

      // sticky flag; a new event in the clear cycle wins
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          flags_r[g] <= STATUS_RESET[g];
        else if (clk_en)
        begin
          if (detect_save[g])
            flags_r[g] <= 1'b1;
          else if (clear_errors)
            flags_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // index passed status; synced event beats a same-cycle clear
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      index_r <= STATUS_RESET[INDEX_PASSED_BIT];
    else if (clk_en)
    begin
      if (index_synced)
        index_r <= 1'b1;
      else if (index_lost)
        index_r <= 1'b0;
      else if (cmd_write && (reg_wdata[CLEAR_INDEX_BIT] || reg_wdata[CLEAR_COUNT_BIT]))
        index_r <= 1'b0;
    end
  end

  // hardware address adopted only on the latch command
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      address_r <= ADDRESS_RESET;
    else if (clk_en && cmd_write && reg_wdata[LATCH_ADDRESS_BIT])
      address_r <= pins_sync;
  end
  assign bus_address = address_r;

  // store strobe to the nonvolatile sequencer; one cycle only, so a
  // single write can never start two copies into the memory
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      store_config_cmd <= 1'b0;
    else if (clk_en)
      store_config_cmd <= cmd_write && reg_wdata[STORE_CONFIG_BIT];
  end

  // load strobe; the config register block performs the copy itself
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      load_config_cmd <= 1'b0;
    else if (clk_en)
      load_config_cmd <= cmd_write && reg_wdata[LOAD_CONFIG_BIT];
  end

  // centring strobe to the gain and offset correction loops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reset_correction_loops_cmd <= 1'b0;
    else if (clk_en)
      reset_correction_loops_cmd <= cmd_write && reg_wdata[RESET_LOOPS_BIT];
  end

  // count clear strobe; the flags here clear on the same edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      clear_count_and_errors_cmd <= 1'b0;
    else if (clk_en)
      clear_count_and_errors_cmd <= clear_errors;
  end

  // status word view; upper fields belong to other blocks and read zero
  always_comb
  begin
    error_status                          = STATUS_RESET;
    error_status[ERROR_FLAG_COUNT-1:0]    = flags_r;
    error_status[INDEX_PASSED_BIT]        = index_r;
  end

  // read answer flag, one cycle after every taken read
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rvalid <= 1'b0;
    else if (clk_en)
      reg_rvalid <= reg_rd;
  end

  // read data; command address is write-only and returns zero, and the
  // word stands until the next enabled edge for the host to take
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (clk_en)
    begin
      if (reg_rd && reg_addr == STATUS_ADDR)
        reg_rdata <= error_status;
      else
        reg_rdata <= '0;
    end
  end
endmodule

// ### verilog/iec_pkg.sv
// constants for the error status and command register bank
package iec_pkg;
  // register addresses
  localparam logic [7:0] STATUS_ADDR      = 8'h08;
  localparam logic [7:0] COMMAND_ADDR     = 8'h0b;
  localparam logic [7:0] CONFIG_ONE_ADDR0 = 8'h0c;
  // status field positions
  localparam int SMALL_VECTOR_BIT    = 0;
  localparam int COS_OVERDRIVE_BIT   = 1;
  localparam int SIN_OVERDRIVE_BIT   = 2;
  localparam int OVERSPEED_BIT       = 3;
  localparam int OUTPUT_INVALID_BIT  = 4;
  localparam int COS_GAIN_BIT        = 5;
  localparam int SIN_GAIN_BIT        = 6;
  localparam int COS_OFFSET_BIT      = 7;
  localparam int SIN_OFFSET_BIT      = 8;
  localparam int INDEX_PASSED_BIT    = 12;
  localparam int ERROR_FLAG_COUNT    = 9;
  // command bit positions
  localparam int CLEAR_COUNT_BIT     = 0;
  localparam int RESET_LOOPS_BIT     = 1;
  localparam int CLEAR_INDEX_BIT     = 2;
  localparam int LOAD_CONFIG_BIT     = 3;
  localparam int STORE_CONFIG_BIT    = 4;
  localparam int LATCH_ADDRESS_BIT   = 5;
  // config word one save-enable and monitor-enable bits
  localparam int SAVE_VECTOR_BIT     = 24;
  localparam int SAVE_CONVERTER_BIT  = 25;
  localparam int SAVE_SPEED_BIT      = 26;
  localparam int SAVE_OUTPUT_BIT     = 27;
  localparam int SAVE_GAIN_BIT       = 28;
  localparam int SAVE_OFFSET_BIT     = 29;
  localparam int MON_VECTOR_BIT      = 16;
  localparam int MON_CONVERTER_BIT   = 17;
  localparam int MON_SPEED_BIT       = 18;
  localparam int MON_OUTPUT_BIT      = 19;
  localparam int MON_GAIN_BIT        = 20;
  localparam int MON_OFFSET_BIT      = 21;
  // reset values
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [3:0]  ADDRESS_RESET = 4'h0;
endpackage

// ### verilog/iec_sync.sv
// two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ps
module iec_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else if (clk_en)
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ### tb/iec_bank_monitor.sv
// assertion checker for the error status and command bank
`timescale 1ns/1ps
module iec_bank_monitor
  import iec_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [31:0] config_word_one,
  input wire logic        rate_setting_changed,
  input wire logic        sine_offset_limit,
  input wire logic        output_too_fast,
  input wire logic        address_pin_3,
  input wire logic        address_pin_2,
  input wire logic        address_pin_1,
  input wire logic        address_pin_0,
  input wire logic [3:0]  bus_address,
  input wire logic        store_config_cmd,
  input wire logic        load_config_cmd,
  input wire logic        reset_correction_loops_cmd,
  input wire logic        clear_count_and_errors_cmd,
  input wire logic        square_wave_mode,
  input wire logic [15:0] error_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // decoded write and strobe groups
  wire       cmd_wr   = clk_en && reg_wr && reg_addr == COMMAND_ADDR;
  wire [3:0] cmd_bits = {reg_wdata[4:3], reg_wdata[1:0]};
  wire [3:0] pins     = {address_pin_3, address_pin_2, address_pin_1, address_pin_0};
  wire [3:0] strb     = {store_config_cmd, load_config_cmd,
                         reset_correction_loops_cmd, clear_count_and_errors_cmd};
  wire [31:0] cfg     = config_word_one;
  // pins must settle through the synchroniser before a latch counts
  sequence s_pins_steady;
    (clk_en && $stable(pins)) [*4];
  endsequence
  sequence s_latch;
    cmd_wr && reg_wdata[LATCH_ADDRESS_BIT];
  endsequence
  AST_READ_ANSWER: assert property (clk_en && reg_rd |=> reg_rvalid)
    else $error("read gave no answer");
  AST_STATUS_DATA: assert property (clk_en && reg_rd && reg_addr == STATUS_ADDR
    |=> reg_rdata == $past(error_status)) else $error("status read data wrong");
  AST_OTHER_READ: assert property (clk_en && reg_rd && reg_addr != STATUS_ADDR
    |=> reg_rdata == 16'h0000) else $error("non-status read not zero");
  AST_IDLE_CMD: assert property (clk_en && reg_wr
    && (reg_addr != COMMAND_ADDR || cmd_bits == 4'h0) |=> strb == 4'h0)
    else $error("strobe without command");
  AST_STROBES: assert property (cmd_wr |=> strb == $past(cmd_bits))
    else $error("command strobes wrong");
  AST_CLEAR_FLAGS: assert property (cmd_wr && reg_wdata[CLEAR_COUNT_BIT]
    && !sine_offset_limit && !output_too_fast && !rate_setting_changed
    |=> !error_status[SIN_OFFSET_BIT] && !error_status[OUTPUT_INVALID_BIT])
    else $error("clear left flags set");
  AST_SIN_OFFSET: assert property (clk_en && sine_offset_limit && cfg[MON_OFFSET_BIT]
    && cfg[SAVE_OFFSET_BIT] |=> error_status[SIN_OFFSET_BIT]) else $error("offset flag missed");
  AST_RATE_CHANGE: assert property (clk_en && rate_setting_changed && cfg[MON_OUTPUT_BIT]
    && cfg[SAVE_OUTPUT_BIT] |=> error_status[OUTPUT_INVALID_BIT]) else $error("rate flag missed");
  AST_COUNTER_MODE: assert property (!cfg[MON_OUTPUT_BIT] && !error_status[OUTPUT_INVALID_BIT]
    |=> !error_status[OUTPUT_INVALID_BIT]) else $error("invalid flag in counter mode");
  AST_NOT_SAVED: assert property (!cfg[SAVE_OFFSET_BIT] && !error_status[SIN_OFFSET_BIT]
    |=> !error_status[SIN_OFFSET_BIT]) else $error("unsaved flag held");
  AST_MODE: assert property (square_wave_mode == cfg[MON_OUTPUT_BIT])
    else $error("mode does not follow monitor bit");
  AST_FREEZE: assert property (!clk_en |=> $stable(error_status) && $stable(strb)
    && $stable(bus_address)) else $error("state moved while disabled");
  AST_LATCH: assert property (s_pins_steady ##0 s_latch |=> bus_address == $past(pins))
    else $error("address pins not latched");
endmodule

bind iec_bank iec_bank_monitor u_mon (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .config_word_one, .rate_setting_changed,
  .sine_offset_limit, .output_too_fast, .address_pin_3, .address_pin_2, .address_pin_1,
  .address_pin_0, .bus_address, .store_config_cmd, .load_config_cmd,
  .reset_correction_loops_cmd, .clear_count_and_errors_cmd, .square_wave_mode, .error_status);

// ### tb/iec_host_model.sv
// register-port host model standing in for the serial interface
`timescale 1ns/1ps
module iec_host_model
(
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  // one-cycle access; idle buses show the inverse so stale values never pass
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(negedge core_clk);
    reg_addr  = ~a;
    reg_wdata = ~d;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  endtask
endmodule

// ### tb/iec_bank_tb_top.sv
// self-checking bench for the error status and command bank
`timescale 1ns/1ps
module iec_bank_tb_top;
  import iec_pkg::*;
  logic        core_clk, rst_n, rate_setting_changed, index_synced, clk_en;
  logic [31:0] config_word_one;
  logic [8:0]  ev;
  logic [3:0]  pins, bus_address, strb;
  logic [7:0]  reg_addr, reg_wdata;
  logic        reg_wr, reg_rd, reg_rvalid, square_wave_mode;
  logic        store_config_cmd, load_config_cmd;
  logic        reset_correction_loops_cmd, clear_count_and_errors_cmd;
  logic [15:0] reg_rdata, error_status, expst;
  logic [31:0] lfsr = 32'hf3d9;
  logic [15:0] rq[$];
  logic [3:0]  sq[$];
  int          fail_count, compares;
  assign strb = {store_config_cmd, load_config_cmd,
                 reset_correction_loops_cmd, clear_count_and_errors_cmd};
  iec_bank dut (.core_clk, .rst_n, .clk_en, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .config_word_one, .rate_setting_changed,
    .sine_offset_limit(ev[8]), .cosine_offset_limit(ev[7]), .sine_gain_limit(ev[6]),
    .cosine_gain_limit(ev[5]), .output_too_fast(ev[4]), .direction_too_fast(ev[3]),
    .sine_converter_over(ev[2]), .cosine_converter_over(ev[1]), .vector_too_small(ev[0]),
    .index_synced, .index_lost(1'b0), .address_pin_3(pins[3]), .address_pin_2(pins[2]),
    .address_pin_1(pins[1]), .address_pin_0(pins[0]), .bus_address, .store_config_cmd,
    .load_config_cmd, .reset_correction_loops_cmd, .clear_count_and_errors_cmd,
    .square_wave_mode, .error_status);
  iec_host_model host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask
  // only strobing bits leave a note; bit 2 and bit 5 act silently
  task automatic cmd(input logic [7:0] a, input logic [7:0] w);
    if (a == COMMAND_ADDR && {w[4:3], w[1:0]} != 4'h0)
      sq.push_back({w[4:3], w[1:0]});
    host.access(a, w, 1'b1);
  endtask
  task automatic pulse(input logic [8:0] e, input logic r, input logic s);
    @(negedge core_clk);
    ev = e;
    rate_setting_changed = r;
    index_synced = s;
    @(negedge core_clk);
    ev = 9'h000;
    rate_setting_changed = 1'b0;
    index_synced = 1'b0;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // result watcher: an unexpected answer meets an unknown note and fails
  always @(negedge core_clk)
  begin
    if (reg_rvalid === 1'b1)
      chk("read data", rq.size() > 0 ? rq.pop_front() : 16'hxxxx, reg_rdata);
    if (strb !== 4'h0)
      chk("strobes", {12'h000, sq.size() > 0 ? sq.pop_front() : 4'hx}, {12'h000, strb});
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    config_word_one = 32'h3f3f0000;
    ev = 9'h000;
    rate_setting_changed = 1'b0;
    index_synced = 1'b0;
    lfsr = step(lfsr);
    pins = lfsr[3:0];
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    rd(STATUS_ADDR, STATUS_RESET);
    rd(COMMAND_ADDR, 16'h0000);
    chk("address reset", {12'h000, ADDRESS_RESET}, {12'h000, bus_address});
    cmd(COMMAND_ADDR, 8'h20);
    chk("address", {12'h000, pins}, {12'h000, bus_address});
    $display("test reset and latch done");
    expst = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      lfsr = step(lfsr);
      pulse(lfsr[8:0], lfsr[9], lfsr[10]);
      expst = expst | {3'h0, lfsr[10], 3'h0, lfsr[8:0] | {4'h0, lfsr[9], 4'h0}};
      rd(STATUS_ADDR, expst);
      if (i[0])
      begin
        cmd(COMMAND_ADDR, 8'h01);
        expst = 16'h0000;
        rd(STATUS_ADDR, expst);
      end
    end
    pulse(9'h000, 1'b0, 1'b1);
    rd(STATUS_ADDR, 16'h1000);
    cmd(COMMAND_ADDR, 8'h04);
    rd(STATUS_ADDR, 16'h0000);
    $display("test flags done");
    for (int b = 1; b < 5; b++)
      cmd(COMMAND_ADDR, 8'(1 << b));
    cmd(COMMAND_ADDR, 8'h1b);
    cmd(COMMAND_ADDR, 8'h00);
    cmd(8'h0a, 8'h1f);
    $display("test commands done");
    config_word_one = 32'h003f0000;
    pulse(9'h1ff, 1'b1, 1'b0);
    rd(STATUS_ADDR, 16'h0000);
    config_word_one = 32'h3f370000;
    pulse(9'h010, 1'b1, 1'b0);
    rd(STATUS_ADDR, 16'h0000);
    chk("mode", 16'h0000, {15'h0000, square_wave_mode});
    config_word_one = 32'h3f000000;
    pulse(9'h1ff, 1'b1, 1'b0);
    rd(STATUS_ADDR, 16'h0000);
    config_word_one = 32'h3f3f0000;
    // events during a frozen clock must leave no trace
    clk_en = 1'b0;
    pulse(9'h1ff, 1'b1, 1'b1);
    clk_en = 1'b1;
    rd(STATUS_ADDR, 16'h0000);
    pulse(9'h000, 1'b1, 1'b0);
    rd(STATUS_ADDR, 16'h0010);
    chk("mode", 16'h0001, {15'h0000, square_wave_mode});
    $display("test enables done");
    repeat (3) @(negedge core_clk);
    chk("pending notes", 16'h0000, 16'(rq.size() + sq.size()));
    close_out();
  end
endmodule
